// >>> nvs_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// two-wire master; clock stands high between frames
// ------------------------------------------------
module nvs_master_model (
  // link wires, sda_rel low pulls the data wire
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one link clock; data changes only while clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #12 scl = 1'b1;
    #22 r = sda;
    #2 scl = 1'b0;
    #12;
  endtask
  task automatic start_c();
    sda_rel = 1'b1;
    #12 scl = 1'b1;
    #12 sda_rel = 1'b0;
    #12 scl = 1'b0;
    #12;
  endtask
  task automatic stop_c();
    sda_rel = 1'b0;
    #12 scl = 1'b1;
    #12 sda_rel = 1'b1;
    #24;
  endtask
  // eight bits msb first, then the ninth clock
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ab, a);
  endtask
endmodule // nvs_master_model
`default_nettype wire

// >>> nvs_pkg.sv
`default_nettype none

package nvs_pkg;

  // ----------------------------------------------------------------
  // array geometry and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [8:0] ADDR_STEP = 9'h001;

  // ----------------------------------------------------------------
  // byte framing on the link
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [2:0] BIT_CNT_STEP = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // slave address byte fields
  localparam int SA_TYPE_HI = 7;
  localparam int SA_TYPE_LO = 4;
  localparam int SA_SEL_HI = 3;
  localparam int SA_SEL_LO = 2;
  localparam int SA_PAGE = 1;
  localparam int SA_RW = 0;

  // synchroniser reset levels: an idle link floats high, straps low
  localparam logic [1:0] LINE_IDLE = 2'h3;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  // one synchronised sample of the two link wires
  typedef struct packed {
    logic scl;
    logic sda;
  } nvs_line_t;

  // protocol sequencer
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WORD,
    ST_WDATA,
    ST_ACK_WAIT,
    ST_ACK,
    ST_RDATA,
    ST_RACK_WAIT,
    ST_RACK,
    ST_RSTART
  } nvs_state_t;

endpackage

`default_nettype wire

// >>> nvs_slave.sv
// Contract
// - a STOP seen mid-transfer abandons it and returns the slave to idle.
// - a START anywhere cancels the transfer and awaits a new slave address.
// - respond only if address bits 3..2 equal the two select pins.
// - address bit 1 gives the ninth address bit for reads and writes.
// - address bit 0 set means read, clear means write.
// - in a write, the next byte is the low address; latch all nine bits.
// - reads send no word address; low bits come from the latch.
// - the address latch steps after each data byte and wraps 1FFh to 000h.
// - any number of consecutive data bytes per transfer, no page boundary.
// - in the ninth clock the sender releases data, the receiver pulls low.
// - an unacknowledged byte ends the transfer so the slave can be re-addressed.
// - read: drive eight bits, sample acknowledge, continue on ack, stop on nack.
// - write: take eight bits then drive an acknowledge for each accepted byte.
// - every byte travels most significant bit first.
// - memory changes only on the eighth data bit; earlier START/STOP leaves it.
// - no busy time; the slave address is acknowledged right after a write.
// - write protect high: no data ack, no array update, no address step.
// - write protect low enables all writes; open pin counts as low.
// - after an acknowledged read address, data starts on the next clock.
// - write address, word address, repeated START: address kept, read follows.
// - bits are sampled on clock rise and changed after clock fall.
// - open select pins read as zero in the address compare.
`timescale 1ns/100ps
`default_nettype none

module nvs_slave #(
  // device type nibble; this value is arbitrary
  parameter logic [3:0] DEVICE_TYPE = 4'h5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // two-wire link, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // straps
  input wire logic [1:0] device_select_pins,
  input wire logic write_protect
);

  // ----------------------------------------------------------------
  // pin synchronisation and condition detection
  // ----------------------------------------------------------------
  nvs_pkg::nvs_line_t line_s;
  nvs_pkg::nvs_line_t line_q;
  logic [2:0] strap_s;
  logic [1:0] sel_s;
  logic wp_s;

  // scl is just another asynchronous pin sampled by sys_clk
  nvs_sync #(
    .W(2),
    .RST_VAL(nvs_pkg::LINE_IDLE)
  ) u_line_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din({scl_in, sda_in}),
    .dout(line_s)
  );

  // the bench leaves open straps at zero, as the internal pull-downs would
  nvs_sync #(
    .W(3),
    .RST_VAL(nvs_pkg::STRAP_RESET)
  ) u_strap_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din({device_select_pins, write_protect}),
    .dout(strap_s)
  );

  assign sel_s = strap_s[2:1];
  assign wp_s = strap_s[0];

  // previous settled sample for edge finding
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      line_q <= nvs_pkg::LINE_IDLE;
    end else begin
      line_q <= line_s;
    end
  end

  wire scl_rise = line_s.scl & ~line_q.scl;
  wire scl_fall = ~line_s.scl & line_q.scl;
  // both wires pass equal delay, so sda moves after scl falls stay clean
  wire start_cond = line_s.scl & line_q.scl & line_q.sda & ~line_s.sda;
  wire stop_cond = line_s.scl & line_q.scl & ~line_q.sda & line_s.sda;

  // ----------------------------------------------------------------
  // state, counters and byte decode
  // ----------------------------------------------------------------
  nvs_pkg::nvs_state_t state;
  nvs_pkg::nvs_state_t next_state;
  nvs_pkg::nvs_state_t ack_next;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] txd;
  logic [8:0] addr;
  logic [7:0] mem [nvs_pkg::MEM_DEPTH];

  // receive states and the read state all count rising edges
  wire rx_state = (state == nvs_pkg::ST_ADDR) | (state == nvs_pkg::ST_WORD) |
                  (state == nvs_pkg::ST_WDATA);
  wire count_state = rx_state | (state == nvs_pkg::ST_RDATA);
  wire byte_done = scl_rise & (bit_cnt == nvs_pkg::BIT_LAST);
  wire [7:0] rx_byte = {shift[6:0], line_s.sda};

  // slave address compare
  wire type_ok = rx_byte[nvs_pkg::SA_TYPE_HI:nvs_pkg::SA_TYPE_LO] == DEVICE_TYPE;
  wire sel_ok = rx_byte[nvs_pkg::SA_SEL_HI:nvs_pkg::SA_SEL_LO] == sel_s;
  wire addr_match = type_ok & sel_ok;
  wire addr_done = (state == nvs_pkg::ST_ADDR) & byte_done;
  wire word_done = (state == nvs_pkg::ST_WORD) & byte_done;
  wire data_done = (state == nvs_pkg::ST_WDATA) & byte_done;
  wire read_done = (state == nvs_pkg::ST_RDATA) & byte_done;

  // array write fires only on the eighth bit and only unprotected
  wire wr_fire = data_done & ~wp_s;
  wire addr_inc = wr_fire | read_done;
  wire [8:0] addr_plus = addr + nvs_pkg::ADDR_STEP;
  wire [7:0] rd_byte = mem[addr];

  // load a read byte on the fall that ends the address ack or a master ack
  wire ack_to_read = (state == nvs_pkg::ST_ACK) & (ack_next == nvs_pkg::ST_RDATA);
  wire tx_load = scl_fall & (ack_to_read | (state == nvs_pkg::ST_RSTART));
  wire tx_shift = scl_fall & (state == nvs_pkg::ST_RDATA);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // start and stop outrank every byte-level step
  always_comb begin
    next_state = state;
    if (start_cond) begin
      next_state = nvs_pkg::ST_ADDR;
    end else if (stop_cond) begin
      next_state = nvs_pkg::ST_IDLE;
    end else begin
      case (state)
        nvs_pkg::ST_IDLE: begin
          next_state = nvs_pkg::ST_IDLE;
        end
        nvs_pkg::ST_ADDR: begin
          if (byte_done) begin
            next_state = addr_match ? nvs_pkg::ST_ACK_WAIT : nvs_pkg::ST_IDLE;
          end
        end
        nvs_pkg::ST_WORD: begin
          if (byte_done) begin
            next_state = nvs_pkg::ST_ACK_WAIT;
          end
        end
        nvs_pkg::ST_WDATA: begin
          if (byte_done) begin
            next_state = wp_s ? nvs_pkg::ST_IDLE : nvs_pkg::ST_ACK_WAIT;
          end
        end
        nvs_pkg::ST_ACK_WAIT: begin
          if (scl_fall) begin
            next_state = nvs_pkg::ST_ACK;
          end
        end
        nvs_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_state = ack_next;
          end
        end
        nvs_pkg::ST_RDATA: begin
          if (byte_done) begin
            next_state = nvs_pkg::ST_RACK_WAIT;
          end
        end
        nvs_pkg::ST_RACK_WAIT: begin
          if (scl_fall) begin
            next_state = nvs_pkg::ST_RACK;
          end
        end
        nvs_pkg::ST_RACK: begin
          if (scl_rise) begin
            next_state = line_s.sda ? nvs_pkg::ST_IDLE : nvs_pkg::ST_RSTART;
          end
        end
        nvs_pkg::ST_RSTART: begin
          if (scl_fall) begin
            next_state = nvs_pkg::ST_RDATA;
          end
        end
        default: begin
          next_state = nvs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= nvs_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // where an acknowledge slot leads once it is released
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_next <= nvs_pkg::ST_IDLE;
    end else if (addr_done) begin
      ack_next <= rx_byte[nvs_pkg::SA_RW] ? nvs_pkg::ST_RDATA : nvs_pkg::ST_WORD;
    end else if (word_done | data_done) begin
      ack_next <= nvs_pkg::ST_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // bit counter and shift registers
  // ----------------------------------------------------------------
  // three bits wrap to zero on the eighth rise, so every byte starts clean
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= nvs_pkg::BIT_CNT_RESET;
    end else if (start_cond | stop_cond) begin
      bit_cnt <= nvs_pkg::BIT_CNT_RESET;
    end else if (scl_rise & count_state) begin
      bit_cnt <= bit_cnt + nvs_pkg::BIT_CNT_STEP;
    end
  end

  // incoming bits enter at the bottom, msb first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift <= nvs_pkg::BYTE_RESET;
    end else if (scl_rise & rx_state) begin
      shift <= rx_byte;
    end
  end

  // outgoing byte leaves from the top, msb first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txd <= nvs_pkg::BYTE_RESET;
    end else if (tx_load) begin
      txd <= rd_byte;
    end else if (tx_shift) begin
      txd <= {txd[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // address latch and array
  // ----------------------------------------------------------------
  // the page bit is refreshed by every matching address; low bits persist
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr <= nvs_pkg::ADDR_RESET;
    end else if (addr_done & addr_match) begin
      addr[8] <= rx_byte[nvs_pkg::SA_PAGE];
    end else if (word_done) begin
      addr <= {addr[8], rx_byte};
    end else if (addr_inc) begin
      addr <= addr_plus;
    end
  end

  // plain array, no reset: contents are data, not control state
  always_ff @(posedge sys_clk) begin
    if (wr_fire) begin
      mem[addr] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // open drain data driver
  // ----------------------------------------------------------------
  // the pad only ever pulls low; a one is sent by releasing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // every change except the release on reset, start or stop waits for a scl fall so a start or stop is never faked
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sda_oe_n <= 1'b1;
    end else if (start_cond | stop_cond) begin
      sda_oe_n <= 1'b1;
    end else if (scl_fall & (state == nvs_pkg::ST_ACK_WAIT)) begin
      sda_oe_n <= 1'b0;
    end else if (tx_load) begin
      sda_oe_n <= rd_byte[7];
    end else if (scl_fall & (state == nvs_pkg::ST_ACK)) begin
      sda_oe_n <= 1'b1;
    end else if (tx_shift) begin
      sda_oe_n <= txd[6];
    end else if (scl_fall & (state == nvs_pkg::ST_RACK_WAIT)) begin
      sda_oe_n <= 1'b1;
    end
  end

endmodule // nvs_slave

`default_nettype wire

// >>> nvs_slave_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// link-side checks of the slave
// ------------------------------------------------
module nvs_slave_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link and straps
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [1:0] device_select_pins,
  input wire logic write_protect
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic scl_q;
  logic sda_q;
  logic [7:0] since_start;
  // start and stop as seen on the raw pins
  wire start_w = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_w = scl_in & scl_q & ~sda_q & sda_in;
  // pin history; cycle count since start saturates so long reads never wrap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      since_start <= 8'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      since_start <= start_w ? 8'h00 : since_start + {7'h00, ~&since_start};
    end
  end
  property p_low_only; sda_out == 1'b0; endproperty
  a_low_only: assert property (p_low_only) else $error("data drive not low");
  property p_rel_reset; $rose(resetn) |-> sda_oe_n; endproperty
  a_rel_reset: assert property (p_rel_reset) else $error("data held after reset");
  property p_change_low; $changed(sda_oe_n) |-> !scl_q && !$past(scl_q); endproperty
  a_change_low: assert property (p_change_low) else $error("data moved outside clock low");
  property p_hold_high; scl_in && scl_q && $past(scl_q, 2) && $past(scl_q) |-> $stable(sda_oe_n); endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved in clock high");
  property p_stop_idle; stop_w |-> sda_oe_n [*8]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");
  property p_start_rel; start_w |-> sda_oe_n [*8]; endproperty
  a_start_rel: assert property (p_start_rel) else $error("drive after start");
  property p_stands; $fell(sda_oe_n) |-> !sda_oe_n [*8]; endproperty
  a_stands: assert property (p_stands) else $error("drive too short");
  property p_addr_quiet; $fell(sda_oe_n) |-> since_start > 8'h46; endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("drive inside address byte");
  c_start: cover property (start_w);
  c_stop: cover property (stop_w);
  c_drive: cover property ($fell(sda_oe_n));
endmodule // nvs_slave_asserts
`default_nettype wire

// >>> nvs_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// two-stage synchroniser for pins arriving from outside sys_clk
// ------------------------------------------------------------------
module nvs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // asynchronous pins in, settled copy out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // only the second stage is ever read; the first may be metastable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // nvs_sync

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// slave bench: address table, then hand cases
// ------------------------------------------------
module tb_top;
  localparam logic [3:0] DT = 4'h5; // arbitrary device type
  // pins, address byte, expected ack level
  localparam logic [10:0] ROWS [6] = '{{2'b00, DT, 4'h0, 1'b0}, {2'b11, DT, 4'hC, 1'b0},
    {2'b10, DT, 4'h4, 1'b1}, {2'b01, DT, 4'h8, 1'b1}, {2'b11, ~DT, 4'hC, 1'b1}, {2'b10, DT, 4'hA, 1'b0}};
  logic sys_clk, resetn, write_protect, scl, sda_rel, sda_out, sda_oe_n, a;
  logic [1:0] device_select_pins;
  logic [7:0] q;
  int err_count, checked;
  wire sda = sda_rel & (sda_oe_n | sda_out); // pull-up; either side pulls low
  nvs_slave #(.DEVICE_TYPE(DT)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins),
    .write_protect(write_protect));
  nvs_master_model i_master (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // address byte with the strap value; leaves ack level in a
  task automatic adr(input logic pg, input logic rw);
    i_master.start_c();
    i_master.xfer({DT, device_select_pins, pg, rw}, 1'b1, q, a);
    chk_bit("addr ack", 1'b0, a);
  endtask
  task automatic seta(input logic pg, input logic [7:0] w);
    adr(pg, 1'b0);
    i_master.xfer(w, 1'b1, q, a);
    chk_bit("word ack", 1'b0, a);
  endtask
  task automatic wr(input logic [7:0] d, input logic e);
    i_master.xfer(d, 1'b1, q, a);
    chk_bit("data ack", e, a);
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    i_master.xfer(8'hFF, last, q, a);
    chk_byte("read data", e, q);
  endtask
  // a hang is cut short here
  initial begin
    #200000;
    err_count++;
    summarize();
  end
  initial begin
    resetn = 1'b0;
    write_protect = 1'b0;
    device_select_pins = 2'b10;
    repeat (8) @(posedge sys_clk);
    #1 chk_bit("oe_n in reset", 1'b1, sda_oe_n);
    resetn = 1'b1;
    for (int r = 0; r < 6; r++) begin
      @(posedge sys_clk);
      #1 device_select_pins = ROWS[r][10:9];
      repeat (3) @(posedge sys_clk);
      i_master.start_c();
      i_master.xfer(ROWS[r][8:1], 1'b1, q, a);
      chk_bit("addr ack", ROWS[r][0], a);
      i_master.xfer(8'h00, 1'b1, q, a);
      chk_bit("byte after addr", ROWS[r][0], a);
      i_master.stop_c();
    end
    // sequential writes in both halves, crossing the top of the array
    seta(1'b0, 8'hFE);
    wr(8'hA1, 1'b0);
    wr(8'hA2, 1'b0);
    seta(1'b1, 8'hFF);
    wr(8'hB1, 1'b0);
    wr(8'hB2, 1'b0);
    i_master.stop_c();
    // random read by repeated start, wrapping to the bottom
    seta(1'b1, 8'hFF);
    adr(1'b1, 1'b1);
    rd(8'hB1, 1'b0);
    rd(8'hB2, 1'b1);
    i_master.stop_c();
    seta(1'b0, 8'hFE);
    adr(1'b0, 1'b1);
    rd(8'hA1, 1'b0);
    rd(8'hA2, 1'b1);
    i_master.stop_c();
    // protected byte: refused, array and latch untouched
    seta(1'b0, 8'h10);
    wr(8'h3C, 1'b0);
    i_master.stop_c();
    @(posedge sys_clk);
    #1 write_protect = 1'b1;
    seta(1'b0, 8'h10);
    wr(8'h55, 1'b1);
    i_master.stop_c();
    @(posedge sys_clk);
    #1 write_protect = 1'b0;
    adr(1'b0, 1'b1);
    rd(8'h3C, 1'b1);
    i_master.stop_c();
    // partial bytes cut by stop and by start leave the array alone
    seta(1'b0, 8'h10);
    for (int i = 0; i < 4; i++) i_master.bit_io(1'b1, a);
    i_master.stop_c();
    seta(1'b0, 8'h10);
    for (int i = 0; i < 5; i++) i_master.bit_io(1'b0, a);
    adr(1'b0, 1'b1);
    rd(8'h3C, 1'b1);
    i_master.stop_c();
    // mid-run reset while the slave pulls data low: release at once, latch back to 000h
    seta(1'b0, 8'hFE);
    adr(1'b0, 1'b1);
    rd(8'hA1, 1'b0);
    i_master.bit_io(1'b1, a);
    repeat (2) @(posedge sys_clk);
    #1 chk_bit("read bit before reset", 1'b0, sda_oe_n);
    @(posedge sys_clk);
    #1 resetn = 1'b0;
    #1 chk_bit("oe_n in mid-run reset", 1'b1, sda_oe_n);
    repeat (8) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge sys_clk);
    adr(1'b0, 1'b1);
    rd(8'hB2, 1'b1);
    i_master.stop_c();
    summarize();
  end
endmodule // tb_top
bind nvs_slave nvs_slave_asserts i_chk (.sys_clk(sys_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins), .write_protect(write_protect));
`default_nettype wire
